// ==== rtl/rsw_reference_switch.v ====
// Reference input switch: picks which of two reference inputs feeds the first loop.
// Assumes activity monitors, lock detector and GPIO select are synchronous inputs.
// Summary of operation
// - An input with priority code 00 is never picked automatically.
// - Priority codes 01, 10, 11 rank inputs upward; 11 is highest.
// - On equal priority input zero wins over input one.
// - Mask clear: loss of lock or selected reference inactivity shows unlocked.
// - Mask set: only loss of lock updates both lock status bits.
// - Mask set: reference loss does not raise the GPIO failure indication.
// - Revertive enable is ignored in the manual selection modes.
// - Revertive off: while the selected input is active a recovering input does not change the selection.
// - Revertive on: recovery reruns selection, switching only to a higher rank.
// - Revertive enable resets to zero.
// - Mode 00 manual, 01 auto, 10 manual, 11 auto with holdover.
// - Manual select 00 picks input zero, 01 input one, others reserved.
// - Automatic modes choose by activity and priority in a state machine.
// - A GPIO input selection overrides the selection mode.
`timescale 1ns/1ps
`include "rsw_map.vh"

module rsw_reference_switch (
    input wire clock_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire sdi_i,
    output wire sdo_o,
    output wire sdo_oe_o,
    input wire [1:0] ref_active_i,
    input wire first_loop_lol_i,
    input wire gpio_sel_en_i,
    input wire gpio_sel_i,
    output reg ref_sel_o,
    output reg holdover_o,
    output reg first_loop_lock_state_o,
    output reg first_loop_lock_latched_o,
    output reg ref_fail_o,
    output wire [7:0] holdoff_count_o,
    output wire [1:0] holdoff_prescale_o,
    output wire [1:0] switch_aux_field_o
);
    // ======================================================================
    // States
    localparam [1:0] ST_MANUAL = 2'b00;
    localparam [1:0] ST_AUTO = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    // ======================================================================
    // Configuration registers
    reg [1:0] prio0_q;
    reg [1:0] prio1_q;
    reg ref_loss_mask_q;
    reg revertive_enable_q;
    reg [1:0] selection_mode_q;
    reg [1:0] manual_sel_q;
    reg [7:0] holdoff_count_q;
    reg [1:0] holdoff_prescale_q;
    reg [1:0] switch_aux_field_q;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg sel_q;
    reg sel_d;
    reg [1:0] active_q;
    reg latched_q;

    wire wr;
    wire [6:0] addr;
    wire [7:0] wdata;
    reg [7:0] rdata;

    // ======================================================================
    // Ranking functions
    // Rank is priority code with a tie-break bit favouring input zero
    function [2:0] rank_of;
        input [1:0] prio;
        input idx;
        begin
            rank_of = {prio, ~idx};
        end
    endfunction

    // Returns {valid, index} of the best active input with nonzero priority
    function [1:0] best_input;
        input [1:0] p0;
        input [1:0] p1;
        input [1:0] act;
        reg ok0;
        reg ok1;
        begin
            ok0 = act[0] && (p0 != `RSW_PRIO_NONE);
            ok1 = act[1] && (p1 != `RSW_PRIO_NONE);
            if (ok0 && ok1) begin
                best_input = {1'b1, (rank_of(p1, 1'b1) > rank_of(p0, 1'b0))};
            end else if (ok0) begin
                best_input = 2'b10;
            end else if (ok1) begin
                best_input = 2'b11;
            end else begin
                best_input = 2'b00;
            end
        end
    endfunction

    // ======================================================================
    // Serial configuration port
    rsw_serial_port u_port (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cs_n_i(cs_n_i),
        .sclk_i(sclk_i),
        .sdi_i(sdi_i),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o),
        .wr_o(wr),
        .addr_o(addr),
        .wdata_o(wdata),
        .rdata_i(rdata)
    );

    // ======================================================================
    // Register write
    always @(posedge clock_i) begin
        if (rst_i) begin
            prio0_q <= `RSW_RST_PRIO0;
            prio1_q <= `RSW_RST_PRIO1;
            ref_loss_mask_q <= `RSW_RST_MASK;
            revertive_enable_q <= `RSW_RST_REVERTIVE_ENABLE;
            selection_mode_q <= `RSW_RST_MODE;
            manual_sel_q <= `RSW_RST_SEL;
            holdoff_count_q <= `RSW_RST_HOLDOFF_COUNT;
            holdoff_prescale_q <= `RSW_RST_PRESCALE;
            switch_aux_field_q <= `RSW_RST_AUX;
        end else if (wr) begin
            case (addr)
                `RSW_ADDR_PRIORITY: begin
                    prio0_q <= wdata[`RSW_PRIO0_HI:`RSW_PRIO0_LO];
                    prio1_q <= wdata[`RSW_PRIO1_HI:`RSW_PRIO1_LO];
                end
                `RSW_ADDR_MODE: begin
                    ref_loss_mask_q <= wdata[`RSW_MASK_BIT];
                    revertive_enable_q <= wdata[`RSW_REVERTIVE_ENABLE_BIT];
                    selection_mode_q <= wdata[`RSW_MODE_HI:`RSW_MODE_LO];
                    manual_sel_q <= wdata[`RSW_SEL_HI:`RSW_SEL_LO];
                end
                `RSW_ADDR_HOLDOFF_COUNT: begin
                    holdoff_count_q <= wdata;
                end
                `RSW_ADDR_HOLDOFF_DIV: begin
                    holdoff_prescale_q <= wdata[`RSW_PRESCALE_HI:`RSW_PRESCALE_LO];
                    switch_aux_field_q <= wdata[`RSW_AUX_HI:`RSW_AUX_LO];
                end
                default: begin
                end
            endcase
        end
    end

    assign holdoff_count_o = holdoff_count_q;
    assign holdoff_prescale_o = holdoff_prescale_q;
    assign switch_aux_field_o = switch_aux_field_q;

    // ======================================================================
    // Register read, reserved bits as zero
    always @* begin
        rdata = 8'h00;
        case (addr)
            `RSW_ADDR_PRIORITY: begin
                rdata[`RSW_PRIO0_HI:`RSW_PRIO0_LO] = prio0_q;
                rdata[`RSW_PRIO1_HI:`RSW_PRIO1_LO] = prio1_q;
            end
            `RSW_ADDR_MODE: begin
                rdata[`RSW_MASK_BIT] = ref_loss_mask_q;
                rdata[`RSW_REVERTIVE_ENABLE_BIT] = revertive_enable_q;
                rdata[`RSW_MODE_HI:`RSW_MODE_LO] = selection_mode_q;
                rdata[`RSW_SEL_HI:`RSW_SEL_LO] = manual_sel_q;
            end
            `RSW_ADDR_HOLDOFF_COUNT: begin
                rdata = holdoff_count_q;
            end
            `RSW_ADDR_HOLDOFF_DIV: begin
                rdata[`RSW_PRESCALE_HI:`RSW_PRESCALE_LO] = holdoff_prescale_q;
                rdata[`RSW_AUX_HI:`RSW_AUX_LO] = switch_aux_field_q;
            end
            `RSW_ADDR_STATUS: begin
                rdata[`RSW_ST_SEL_BIT] = sel_q;
                rdata[`RSW_ST_LOCK_BIT] = first_loop_lock_state_o;
                rdata[`RSW_ST_LATCH_BIT] = latched_q;
                rdata[`RSW_ST_HOLD_BIT] = holdover_o;
            end
            default: begin
                rdata = 8'h00;
            end
        endcase
    end

    // ======================================================================
    // Selection state machine
    wire auto_mode = selection_mode_q[0];
    wire hold_mode = selection_mode_q[1];
    wire [1:0] best = best_input(prio0_q, prio1_q, ref_active_i);
    wire cur_active = ref_active_i[sel_q];
    wire [1:0] recovered = ref_active_i & ~active_q;
    // Only a recovering input that is not the current one triggers reselection
    wire other_recovered = sel_q ? recovered[0] : recovered[1];
    // Revertive bit only has meaning in automatic modes
    wire revert_on = revertive_enable_q & auto_mode;
    wire [2:0] cur_rank = rank_of(sel_q ? prio1_q : prio0_q, sel_q);
    wire [2:0] best_rank = rank_of(best[0] ? prio1_q : prio0_q, best[0]);

    always @* begin
        state_d = state_q;
        sel_d = sel_q;
        if (gpio_sel_en_i) begin
            state_d = ST_MANUAL;
            sel_d = gpio_sel_i;
        end else begin
            case (state_q)
                ST_MANUAL: begin
                    if (auto_mode) begin
                        state_d = ST_AUTO;
                    end else if (manual_sel_q == `RSW_SEL_IN0) begin
                        sel_d = 1'b0;
                    end else if (manual_sel_q == `RSW_SEL_IN1) begin
                        sel_d = 1'b1;
                    end
                end
                ST_AUTO: begin
                    if (!auto_mode) begin
                        state_d = ST_MANUAL;
                    end else if (!cur_active) begin
                        if (best[1]) begin
                            sel_d = best[0];
                        end else if (hold_mode) begin
                            state_d = ST_HOLD;
                        end
                    end else if (other_recovered && revert_on && best[1]) begin
                        // Switch only if the recovered input outranks the current one
                        if (best_rank > cur_rank) begin
                            sel_d = best[0];
                        end
                    end
                    // Without revertive switching a recovery leaves sel_d unchanged
                end
                ST_HOLD: begin
                    if (!auto_mode) begin
                        state_d = ST_MANUAL;
                    end else if (best[1]) begin
                        state_d = ST_AUTO;
                        sel_d = best[0];
                    end
                end
                default: begin
                    state_d = ST_MANUAL;
                end
            endcase
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= ST_MANUAL;
            sel_q <= 1'b0;
            active_q <= 2'b00;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            active_q <= ref_active_i;
        end
    end

    // ======================================================================
    // Lock status and failure indication
    // Reference loss counts toward unlock only while the mask is clear
    wire ref_lost = ~ref_loss_mask_q & ~cur_active;
    wire unlocked = first_loop_lol_i | ref_lost;
    wire latch_clr = wr && (addr == `RSW_ADDR_STATUS) && wdata[`RSW_ST_LATCH_BIT];

    always @(posedge clock_i) begin
        if (rst_i) begin
            latched_q <= 1'b0;
            ref_sel_o <= 1'b0;
            holdover_o <= 1'b0;
            first_loop_lock_state_o <= 1'b0;
            first_loop_lock_latched_o <= 1'b0;
            ref_fail_o <= 1'b0;
        end else begin
            // Set wins over a simultaneous clear
            if (unlocked) begin
                latched_q <= 1'b1;
            end else if (latch_clr) begin
                latched_q <= 1'b0;
            end
            ref_sel_o <= sel_q;
            holdover_o <= (state_q == ST_HOLD);
            first_loop_lock_state_o <= ~unlocked;
            first_loop_lock_latched_o <= latched_q;
            ref_fail_o <= ref_lost;
        end
    end
endmodule

// ==== include/rsw_map.vh ====
// Register map, field positions and reset values of the reference input switch.
// Included by the switch logic and its serial configuration port.
`ifndef RSW_MAP_VH
`define RSW_MAP_VH

// ==========================================================================
// Register addresses
`define RSW_ADDR_PRIORITY 7'h34
`define RSW_ADDR_MODE 7'h35
`define RSW_ADDR_HOLDOFF_COUNT 7'h36
`define RSW_ADDR_HOLDOFF_DIV 7'h37
`define RSW_ADDR_STATUS 7'h38

// ==========================================================================
// Field positions
`define RSW_PRIO0_HI 7
`define RSW_PRIO0_LO 6
`define RSW_PRIO1_HI 5
`define RSW_PRIO1_LO 4
`define RSW_MASK_BIT 6
`define RSW_REVERTIVE_ENABLE_BIT 5
`define RSW_MODE_HI 3
`define RSW_MODE_LO 2
`define RSW_SEL_HI 1
`define RSW_SEL_LO 0
`define RSW_PRESCALE_HI 7
`define RSW_PRESCALE_LO 6
`define RSW_AUX_HI 1
`define RSW_AUX_LO 0
`define RSW_ST_SEL_BIT 0
`define RSW_ST_LOCK_BIT 1
`define RSW_ST_LATCH_BIT 2
`define RSW_ST_HOLD_BIT 3

// ==========================================================================
// Reset values
`define RSW_RST_PRIO0 2'h3
`define RSW_RST_PRIO1 2'h2
`define RSW_RST_MASK 1'h0
`define RSW_RST_REVERTIVE_ENABLE 1'h0
`define RSW_RST_MODE 2'h0
`define RSW_RST_SEL 2'h0
`define RSW_RST_HOLDOFF_COUNT 8'h80
`define RSW_RST_PRESCALE 2'h0
`define RSW_RST_AUX 2'h0

// ==========================================================================
// Encodings
`define RSW_PRIO_NONE 2'h0
`define RSW_SEL_IN0 2'h0
`define RSW_SEL_IN1 2'h1

// ==========================================================================
// Serial frame
`define RSW_FRAME_BITS 5'h10
`define RSW_HEAD_BITS 5'h08

`endif

// ==== rtl/rsw_serial_port.v ====
// Serial configuration port: 16-bit frames, read flag, 7-bit address, 8-bit data.
// Assumes chip select, serial clock and data in are synchronous to clock_i.
`timescale 1ns/1ps
`include "rsw_map.vh"

module rsw_serial_port (
    input wire clock_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire sdi_i,
    output wire sdo_o,
    output wire sdo_oe_o,
    output reg wr_o,
    output reg [6:0] addr_o,
    output reg [7:0] wdata_o,
    input wire [7:0] rdata_i
);
    reg sclk_q;
    reg [4:0] count_q;
    reg [7:0] shift_q;
    reg [7:0] out_q;
    reg read_q;
    wire rise = sclk_i & ~sclk_q;
    wire fall = ~sclk_i & sclk_q;

    assign sdo_o = out_q[7];
    assign sdo_oe_o = ~cs_n_i & read_q & (count_q >= `RSW_HEAD_BITS);

    // ======================================================================
    // Shift engine: sample on rising edge, shift read data on falling edge
    always @(posedge clock_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            count_q <= 5'h00;
            shift_q <= 8'h00;
            out_q <= 8'h00;
            read_q <= 1'b0;
            wr_o <= 1'b0;
            addr_o <= 7'h00;
            wdata_o <= 8'h00;
        end else begin
            sclk_q <= sclk_i;
            wr_o <= 1'b0;
            if (cs_n_i) begin
                count_q <= 5'h00;
                read_q <= 1'b0;
            end else if (rise && count_q < `RSW_FRAME_BITS) begin
                shift_q <= {shift_q[6:0], sdi_i};
                count_q <= count_q + 5'h01;
                if (count_q == `RSW_HEAD_BITS - 5'h01) begin
                    read_q <= shift_q[6];
                    addr_o <= {shift_q[5:0], sdi_i};
                end
                if (count_q == `RSW_FRAME_BITS - 5'h01) begin
                    wdata_o <= {shift_q[6:0], sdi_i};
                    wr_o <= ~read_q;
                end
            end else if (fall && count_q == `RSW_HEAD_BITS) begin
                out_q <= rdata_i;
            end else if (fall && count_q > `RSW_HEAD_BITS) begin
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end
endmodule

// ==== tb/rsw_ref_source_model.sv ====
// Model of the two redundant reference sources, each with an activity monitor.
// Assumes the bench commands which sources run; all changes land at falling edges.
`timescale 1ns/1ps

module rsw_ref_source_model (
    input wire clock_i,
    input wire [1:0] run_i,
    output wire [1:0] ref_active_o
);
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
            reg clk_q = 1'h0;
            reg last_q = 1'h0;
            reg [1:0] idle_q = 2'h3;
            // A stopped source reads inactive after three quiet cycles
            always @(negedge clock_i) begin
                if (run_i[gi]) begin
                    clk_q <= ~clk_q;
                end
                last_q <= clk_q;
                if (clk_q != last_q) begin
                    idle_q <= 2'h0;
                end else if (idle_q != 2'h3) begin
                    idle_q <= idle_q + 2'h1;
                end
            end
            assign ref_active_o[gi] = (idle_q != 2'h3);
        end
    endgenerate
endmodule

// ==== tb/rsw_switch_assertions.sv ====
// Port assertions of the reference input switch.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module rsw_switch_assertions (
    input wire clock_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire [1:0] ref_active_i,
    input wire first_loop_lol_i,
    input wire gpio_sel_en_i,
    input wire gpio_sel_i,
    input wire ref_sel_o,
    input wire holdover_o,
    input wire first_loop_lock_state_o,
    input wire first_loop_lock_latched_o,
    input wire ref_fail_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // ==================================================================
    // Selection
    AST_GPIO_OVR: assert property ((gpio_sel_en_i && $stable(gpio_sel_i)) [*3]
        |-> ref_sel_o == gpio_sel_i)
        else $error("gpio override not followed");
    AST_SEL_QUIET: assert property ((cs_n_i && $stable(ref_active_i) && $stable(gpio_sel_en_i)
        && $stable(gpio_sel_i)) [*4] |=> $stable(ref_sel_o))
        else $error("selection moved without cause");
    AST_HOLD_QUIET: assert property ((ref_active_i == 2'h3) [*4] |-> !holdover_o)
        else $error("holdover with both inputs active");

    // ==================================================================
    // Lock status and failure indication
    AST_LOL_UNLOCK: assert property (first_loop_lol_i ##1 first_loop_lol_i
        |=> !first_loop_lock_state_o)
        else $error("loss of lock not shown");
    AST_LOCK_GOOD: assert property ((!first_loop_lol_i && ref_active_i == 2'h3) [*4]
        |-> first_loop_lock_state_o)
        else $error("unlocked with no cause");
    AST_FAIL_QUIET: assert property ((ref_active_i == 2'h3) [*4] |-> !ref_fail_o)
        else $error("failure with both inputs active");
    AST_LATCH_SET: assert property ($fell(first_loop_lock_state_o)
        |-> ##[0:2] first_loop_lock_latched_o)
        else $error("unlock not latched");
    AST_LATCH_HOLDS: assert property ((cs_n_i && first_loop_lock_latched_o) [*4]
        |=> first_loop_lock_latched_o)
        else $error("latched unlock lost");
endmodule

bind rsw_reference_switch rsw_switch_assertions i_chk (.clock_i(clock_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .ref_active_i(ref_active_i), .first_loop_lol_i(first_loop_lol_i),
    .gpio_sel_en_i(gpio_sel_en_i), .gpio_sel_i(gpio_sel_i), .ref_sel_o(ref_sel_o),
    .holdover_o(holdover_o), .first_loop_lock_state_o(first_loop_lock_state_o),
    .first_loop_lock_latched_o(first_loop_lock_latched_o), .ref_fail_o(ref_fail_o));

// ==== tb/reference_input_switch_bench.sv ====
// Self-checking bench of the reference input switch over its serial port.
// Assumes the 16-bit serial frame of the switch; inputs change at falling edges.
`timescale 1ns/1ps

module reference_input_switch_bench;
    reg clock_i = 1'h0, rst_i = 1'h1, cs_n_i = 1'h1, sclk_i = 1'h0, sdi_i = 1'h0;
    reg lol_q = 1'h0, gen_q = 1'h0, gsel_q = 1'h0, oe_q = 1'h0;
    reg [1:0] run_q = 2'h3;
    reg [7:0] rd_q = 8'h00;
    wire [1:0] act, hpre, haux;
    wire sdo_o, sdo_oe_o, ref_sel_o, holdover_o, lock_st, lock_lat, ref_fail_o;
    wire [7:0] hcnt;
    integer error_cnt = 0, num_checks = 0;

    always #20 clock_i = ~clock_i;

    rsw_ref_source_model i_src (.clock_i(clock_i), .run_i(run_q), .ref_active_o(act));
    rsw_reference_switch i_dut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
        .sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .ref_active_i(act), .first_loop_lol_i(lol_q), .gpio_sel_en_i(gen_q),
        .gpio_sel_i(gsel_q), .ref_sel_o(ref_sel_o), .holdover_o(holdover_o),
        .first_loop_lock_state_o(lock_st), .first_loop_lock_latched_o(lock_lat),
        .ref_fail_o(ref_fail_o), .holdoff_count_o(hcnt), .holdoff_prescale_o(hpre),
        .switch_aux_field_o(haux));

    // ==================================================================
    // Tasks
    task results;
        begin
            $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(negedge clock_i);
    endtask

    // One frame: read flag, address, data; sdo sampled at the end of each low phase
    task xfer(input is_rd, input [6:0] a, input [7:0] d);
        reg [15:0] f;
        integer i;
        begin
            f = {is_rd, a, d};
            cs_n_i = 1'h0;
            oe_q = 1'h0;
            for (i = 15; i >= 0; i = i - 1) begin
                sdi_i = f[i];
                sclk_i = 1'h0;
                cyc(2);
                rd_q = {rd_q[6:0], sdo_o};
                oe_q = oe_q | sdo_oe_o;
                sclk_i = 1'h1;
                cyc(2);
            end
            sclk_i = 1'h0;
            cyc(2);
            cs_n_i = 1'h1;
            cyc(2);
        end
    endtask

    task wr(input [6:0] a, input [7:0] d);
        begin
            xfer(1'h0, a, d);
            chk("sdo_oe", 8'h00, {7'h00, oe_q});
            cyc(6);
        end
    endtask

    task rchk(input [6:0] a, input [7:0] exp);
        begin
            xfer(1'h1, a, 8'h00);
            chk("sdo_oe", 8'h01, {7'h00, oe_q});
            chk("register", exp, rd_q);
        end
    endtask

    task drop0(input [1:0] after);
        begin
            run_q = 2'h2;
            cyc(8);
            run_q = after;
            cyc(8);
        end
    endtask

    // ==================================================================
    // Tests
    initial begin
        cyc(4);
        rst_i = 1'h0;
        cyc(2);
        rchk(7'h34, 8'hE0);
        rchk(7'h35, 8'h00);
        rchk(7'h36, 8'h80);
        rchk(7'h37, 8'h00);
        rchk(7'h10, 8'h00);
        wr(7'h37, 8'hFF);
        rchk(7'h37, 8'hC3);
        wr(7'h35, 8'hFF);
        rchk(7'h35, 8'h6F);
        wr(7'h36, 8'h5A);
        chk("holdoff", 8'h5A, hcnt);
        chk("prescale", 8'h0F, {4'h0, hpre, haux});
        $display("test registers done");
        wr(7'h35, 8'h01);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        wr(7'h35, 8'h02);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        wr(7'h35, 8'h20);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        drop0(2'h2);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        chk("lock", 8'h00, {7'h00, lock_st});
        chk("fail", 8'h01, {7'h00, ref_fail_o});
        wr(7'h35, 8'h60);
        chk("lock", 8'h01, {7'h00, lock_st});
        chk("fail", 8'h00, {7'h00, ref_fail_o});
        wr(7'h38, 8'h04);
        chk("latched", 8'h00, {7'h00, lock_lat});
        lol_q = 1'h1;
        cyc(4);
        chk("lock", 8'h00, {7'h00, lock_st});
        chk("latched", 8'h01, {7'h00, lock_lat});
        lol_q = 1'h0;
        run_q = 2'h3;
        $display("test manual and lock done");
        wr(7'h34, 8'hE0);
        wr(7'h35, 8'h04);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        drop0(2'h2);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        run_q = 2'h3;
        cyc(8);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        wr(7'h35, 8'h24);
        drop0(2'h3);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        wr(7'h34, 8'h70);
        drop0(2'h3);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        wr(7'h34, 8'h50);
        drop0(2'h3);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        wr(7'h35, 8'h0C);
        wr(7'h34, 8'hC0);
        drop0(2'h2);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        chk("hold", 8'h01, {7'h00, holdover_o});
        run_q = 2'h3;
        cyc(8);
        $display("test automatic done");
        gen_q = 1'h1;
        gsel_q = 1'h1;
        cyc(8);
        chk("sel", 8'h01, {7'h00, ref_sel_o});
        gen_q = 1'h0;
        wr(7'h35, 8'h28);
        chk("sel", 8'h00, {7'h00, ref_sel_o});
        rchk(7'h38, 8'h06);
        $display("test override done");
        results;
    end

    initial begin
        cyc(20000);
        error_cnt = error_cnt + 1;
        $display("[ERR] watchdog expected finish seen timeout");
        results;
    end
endmodule
